//--- design/tw_pkg.sv
// Purpose: constants for the timer watchdog and interrupt register block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: counting engine and prescaler live outside this block
`default_nettype none
package tw_pkg;
	localparam int ADDR_W = 8;
	// byte offsets
	localparam logic [7:0] OFS_WDCTL = 8'h00;
	localparam logic [7:0] OFS_REL_LO = 8'h04;
	localparam logic [7:0] OFS_REL_HI = 8'h08;
	localparam logic [7:0] OFS_CAP_LO = 8'h0C;
	localparam logic [7:0] OFS_CAP_HI = 8'h10;
	localparam logic [7:0] OFS_ICTL = 8'h14;
	localparam logic [7:0] OFS_TCTL = 8'h18;
	localparam logic [7:0] OFS_IRQ_ST = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
	// watchdog control fields
	localparam int WD_KEY_LSB = 16;
	localparam int WD_FLAG_BIT = 15;
	localparam int WD_EN_BIT = 14;
	localparam int WD_RSV_LSB = 12;
	localparam logic [15:0] KEY_FIRST = 16'hA5C6;
	localparam logic [15:0] KEY_SECOND = 16'hDA7E;
	// interrupt control/status fields
	localparam int IC_FORCE_HI = 31;
	localparam int IC_EVAL_HI = 30;
	localparam int IC_EVT_ST_HI = 19;
	localparam int IC_EVT_EN_HI = 18;
	localparam int IC_CMP_ST_HI = 17;
	localparam int IC_CMP_EN_HI = 16;
	localparam int IC_FORCE_LO = 15;
	localparam int IC_EVAL_LO = 14;
	localparam int IC_EVT_ST_LO = 3;
	localparam int IC_EVT_EN_LO = 2;
	localparam int IC_CMP_ST_LO = 1;
	localparam int IC_CMP_EN_LO = 0;
	// timer control fields
	localparam int TC_MODE_LSB = 2;
	localparam int TC_RUN_HI = 1;
	localparam int TC_RUN_LO = 0;
	localparam logic [1:0] MODE_WATCHDOG = 2'h2;
	// system interrupt status layout
	localparam int IRQ_W = 3;
	localparam int IRQ_TIMEOUT = 0;
	localparam int IRQ_HALF_LO = 1;
	localparam int IRQ_HALF_HI = 2;
	// reset values and answers
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- design/tw_regs.sv
// Purpose: timer watchdog control, reload, capture and interrupt registers
// Assumes: engine pulses are one cycle wide and synchronous to aclk
// Notes: force and reevaluate bits are write-only pulses and read as zero
`default_nettype none
module tw_regs (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [tw_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [tw_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// counting engine
	input wire logic [31:0] cnt_low,
	input wire logic [31:0] cnt_high,
	input wire logic match_low,
	input wire logic match_high,
	input wire logic capture_low_evt,
	input wire logic capture_high_evt,
	input wire logic wd_timeout,
	// control out
	output logic [31:0] reload_low_half,
	output logic [31:0] reload_high_half,
	output logic [1:0] timer_mode_select,
	output logic low_half_run,
	output logic high_half_run,
	output logic watchdog_enable,
	output logic watchdog_active,
	output logic wd_service,
	// interrupts
	output logic intr_low,
	output logic intr_high,
	output logic irq
);
	import tw_pkg::*;

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] key;
		logic flag;
		logic wd_en;
		logic [1:0] wd_rsv;
		logic armed;
		logic service;
		logic [31:0] rel_lo;
		logic [31:0] rel_hi;
		logic [31:0] cap_lo;
		logic [31:0] cap_hi;
		logic [1:0] evt_st;
		logic [1:0] evt_en;
		logic [1:0] cmp_st;
		logic [1:0] cmp_en;
		logic [1:0] intr;
		logic [1:0] mode;
		logic [1:0] run;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mask;
	} tw_state_t;

	tw_state_t s;
	tw_state_t next_s;

	function automatic logic tw_mapped(input logic [ADDR_W-1:0] a);
		tw_mapped = (a == OFS_WDCTL) || (a == OFS_REL_LO) || (a == OFS_REL_HI) ||
			(a == OFS_CAP_LO) || (a == OFS_CAP_HI) || (a == OFS_ICTL) ||
			(a == OFS_TCTL) || (a == OFS_IRQ_ST) || (a == OFS_IRQ_MASK);
	endfunction

	function automatic logic [31:0] tw_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		tw_merge = r;
	endfunction

	logic w_go;
	logic [31:0] wm;
	logic [1:0] new_evt;
	logic [1:0] new_cmp;
	logic [1:0] force_wr;
	logic [1:0] eval_wr;
	logic active;
	logic key_full;

	assign active = s.wd_en && (s.mode == MODE_WATCHDOG);
	assign w_go = s.aw_got && s.w_got && !s.bvalid;
	assign key_full = (s.wstrb[3:2] == 2'b11);
	assign new_cmp = {match_high & s.run[1], match_low & s.run[0]};
	assign new_evt = {capture_high_evt, capture_low_evt};

	always_comb begin
		logic wr_wd;
		logic wr_ic;
		logic [15:0] k;
		next_s = s;
		wr_wd = w_go && (s.waddr == OFS_WDCTL);
		wr_ic = w_go && (s.waddr == OFS_ICTL);
		k = s.wdata[WD_KEY_LSB +: 16];
		force_wr = '0;
		eval_wr = '0;
		wm = RST_WORD;
		// write channel capture, either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.aw_got = 1'b1;
			next_s.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (w_go) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = tw_mapped(s.waddr) ? RESP_OKAY : RESP_SLVERR;
		end
		// watchdog control word
		next_s.service = 1'b0;
		if (wr_wd) begin
			wm = tw_merge({s.key, s.flag, s.wd_en, s.wd_rsv, 12'h000}, s.wdata, s.wstrb);
			next_s.key = wm[WD_KEY_LSB +: 16];
			next_s.wd_en = wm[WD_EN_BIT];
			next_s.wd_rsv = wm[WD_RSV_LSB +: 2];
			// key sequence only counts in watchdog mode with a whole key
			if (s.mode == MODE_WATCHDOG && key_full) begin
				next_s.service = s.armed && (k == KEY_SECOND);
				next_s.armed = (k == KEY_FIRST);
			end
			if ((s.wstrb[1] && s.wdata[WD_FLAG_BIT]) || (!s.wd_en && wm[WD_EN_BIT])) begin
				next_s.flag = 1'b0;
			end
		end
		if (wd_timeout) begin
			next_s.flag = 1'b1;
		end
		// reload registers
		if (w_go && s.waddr == OFS_REL_LO) begin
			next_s.rel_lo = tw_merge(s.rel_lo, s.wdata, s.wstrb);
		end
		if (w_go && s.waddr == OFS_REL_HI) begin
			next_s.rel_hi = tw_merge(s.rel_hi, s.wdata, s.wstrb);
		end
		// capture registers
		if (capture_low_evt) begin
			next_s.cap_lo = cnt_low;
		end
		if (capture_high_evt) begin
			next_s.cap_hi = cnt_high;
		end
		// interrupt control/status
		if (wr_ic) begin
			wm = tw_merge(RST_WORD, s.wdata, s.wstrb);
			force_wr = {wm[IC_FORCE_HI], wm[IC_FORCE_LO]};
			eval_wr = {wm[IC_EVAL_HI], wm[IC_EVAL_LO]};
			next_s.evt_en = {wm[IC_EVT_EN_HI], wm[IC_EVT_EN_LO]};
			next_s.cmp_en = {wm[IC_CMP_EN_HI], wm[IC_CMP_EN_LO]};
			if (s.wstrb[2]) begin
				next_s.evt_en[1] = wm[IC_EVT_EN_HI];
				next_s.cmp_en[1] = wm[IC_CMP_EN_HI];
			end else begin
				next_s.evt_en[1] = s.evt_en[1];
				next_s.cmp_en[1] = s.cmp_en[1];
			end
			if (!s.wstrb[0]) begin
				next_s.evt_en[0] = s.evt_en[0];
				next_s.cmp_en[0] = s.cmp_en[0];
			end
			next_s.evt_st = s.evt_st & ~{wm[IC_EVT_ST_HI], wm[IC_EVT_ST_LO]};
			next_s.cmp_st = s.cmp_st & ~{wm[IC_CMP_ST_HI], wm[IC_CMP_ST_LO]};
		end
		// set wins over a clear in the same cycle
		next_s.evt_st = next_s.evt_st | new_evt;
		next_s.cmp_st = next_s.cmp_st | new_cmp;
		for (int h = 0; h < 2; h++) begin
			next_s.intr[h] = force_wr[h] ||
				(eval_wr[h] && (s.evt_st[h] || s.cmp_st[h])) ||
				(new_evt[h] && s.evt_en[h]) ||
				(new_cmp[h] && s.cmp_en[h]);
		end
		// timer control: frozen while the watchdog is active
		if (w_go && s.waddr == OFS_TCTL && s.wstrb[0] && !active) begin
			next_s.run = s.wdata[TC_RUN_HI:TC_RUN_LO];
			next_s.mode = s.wdata[TC_MODE_LSB +: 2];
		end
		// system interrupt status and mask
		if (w_go && s.waddr == OFS_IRQ_ST && s.wstrb[0]) begin
			next_s.irq_st = s.irq_st & ~s.wdata[IRQ_W-1:0];
		end
		if (w_go && s.waddr == OFS_IRQ_MASK && s.wstrb[0]) begin
			next_s.irq_mask = s.wdata[IRQ_W-1:0];
		end
		next_s.irq_st[IRQ_TIMEOUT] = next_s.irq_st[IRQ_TIMEOUT] | wd_timeout;
		next_s.irq_st[IRQ_HALF_LO] = next_s.irq_st[IRQ_HALF_LO] | s.intr[0];
		next_s.irq_st[IRQ_HALF_HI] = next_s.irq_st[IRQ_HALF_HI] | s.intr[1];
		// read channel, answer one cycle after the address is taken
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = tw_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				OFS_WDCTL: next_s.rdata = {s.key, s.flag, s.wd_en, s.wd_rsv, 12'h000};
				OFS_REL_LO: next_s.rdata = s.rel_lo;
				OFS_REL_HI: next_s.rdata = s.rel_hi;
				OFS_CAP_LO: next_s.rdata = s.cap_lo;
				OFS_CAP_HI: next_s.rdata = s.cap_hi;
				OFS_ICTL: next_s.rdata = {12'h000, s.evt_st[1], s.evt_en[1], s.cmp_st[1],
					s.cmp_en[1], 12'h000, s.evt_st[0], s.evt_en[0], s.cmp_st[0], s.cmp_en[0]};
				OFS_TCTL: next_s.rdata = {28'h000_0000, s.mode, s.run};
				OFS_IRQ_ST: next_s.rdata = {29'h0000_0000, s.irq_st};
				OFS_IRQ_MASK: next_s.rdata = {29'h0000_0000, s.irq_mask};
				default: next_s.rdata = RST_WORD;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// handshake outputs
	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready = !s.w_got && !s.bvalid;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	// control and interrupt outputs
	assign reload_low_half = s.rel_lo;
	assign reload_high_half = s.rel_hi;
	assign timer_mode_select = s.mode;
	assign low_half_run = s.run[0];
	assign high_half_run = s.run[1];
	assign watchdog_enable = s.wd_en;
	assign watchdog_active = active;
	assign wd_service = s.service;
	assign intr_low = s.intr[0];
	assign intr_high = s.intr[1];
	assign irq = |(s.irq_st & s.irq_mask);

	// checks
	logic wr_wd_full;
	assign wr_wd_full = w_go && s.waddr == OFS_WDCTL && key_full;

	property p_key_order;
		@(posedge aclk) disable iff (!aresetn)
		wr_wd_full && s.mode == MODE_WATCHDOG && s.armed &&
			s.wdata[WD_KEY_LSB +: 16] == KEY_SECOND |=> wd_service;
	endproperty
	a_key_order: assert property (p_key_order) else $error("second key did not service");

	property p_service_cause;
		@(posedge aclk) disable iff (!aresetn)
		wd_service |-> $past(s.armed) && $past(s.wdata[WD_KEY_LSB +: 16]) == KEY_SECOND;
	endproperty
	a_service_cause: assert property (p_service_cause) else $error("service without keys");

	property p_no_service_gp;
		@(posedge aclk) disable iff (!aresetn)
		w_go && s.mode != MODE_WATCHDOG |=> !wd_service;
	endproperty
	a_no_service_gp: assert property (p_no_service_gp) else $error("serviced in timer mode");

	logic irq_stat_to;
	assign irq_stat_to = s.irq_st[IRQ_TIMEOUT];

	property p_flag_set;
		@(posedge aclk) disable iff (!aresetn)
		wd_timeout |=> s.flag ##0 irq_stat_to;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("time-out flag not set");

	property p_flag_clr;
		@(posedge aclk) disable iff (!aresetn)
		w_go && s.waddr == OFS_WDCTL && s.wstrb[1] && s.wdata[WD_FLAG_BIT] && !wd_timeout
			|=> !s.flag;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared by one");

	property p_force;
		@(posedge aclk) disable iff (!aresetn)
		w_go && s.waddr == OFS_ICTL && s.wstrb[1] && s.wdata[IC_FORCE_LO] |=> intr_low;
	endproperty
	a_force: assert property (p_force) else $error("force did not pulse");

	property p_eval;
		@(posedge aclk) disable iff (!aresetn)
		w_go && s.waddr == OFS_ICTL && s.wstrb[3] && s.wdata[IC_EVAL_HI] &&
			(s.cmp_st[1] || s.evt_st[1]) |=> intr_high;
	endproperty
	a_eval: assert property (p_eval) else $error("reevaluate did not pulse");

	property p_match;
		@(posedge aclk) disable iff (!aresetn)
		match_low && low_half_run |=>
			s.cmp_st[0] ##1 (s.irq_st[IRQ_HALF_LO] || !$past(s.cmp_en[0], 2));
	endproperty
	a_match: assert property (p_match) else $error("match status missing");

	property p_run_lock;
		@(posedge aclk) disable iff (!aresetn)
		active |=> $stable(s.run);
	endproperty
	a_run_lock: assert property (p_run_lock) else $error("run changed while active");

	property p_sticky;
		@(posedge aclk) disable iff (!aresetn)
		s.evt_st[1] && !(w_go && s.waddr == OFS_ICTL) |=> s.evt_st[1];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status lost without clear");

	property p_pulse;
		@(posedge aclk) disable iff (!aresetn)
		intr_low && !$past(w_go) |=>
			!intr_low || $past(match_low || capture_low_evt || w_go);
	endproperty
	a_pulse: assert property (p_pulse) else $error("interrupt not a pulse");

	c_service: cover property (@(posedge aclk) disable iff (!aresetn) wd_service);
	c_timeout_irq: cover property (@(posedge aclk) disable iff (!aresetn) wd_timeout ##2 irq);
	c_evt_intr: cover property (@(posedge aclk) disable iff (!aresetn)
		capture_high_evt ##1 intr_high);
	c_slverr: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid &&
		s_axi_bresp == RESP_SLVERR);
endmodule
`default_nettype wire

//--- tb/tw_regs_bench.sv
// Purpose: self-checking bench for the timer watchdog register block
// Assumes: aclk 125 MHz, synchronous active-low reset, bench is axi4-lite master
// Notes: engine pulses share one event vector so a single task fires any mix
`default_nettype none
module tw_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import tw_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [3:0] s;
		logic [31:0] r;
		logic [1:0] br;
		logic [1:0] rr;
	} tw_row_t;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, cnt_low, cnt_high;
	logic [3:0] wstrb;
	logic [4:0] evts;
	logic [1:0] last_b, last_r;
	wire logic awready, wready, bvalid, arready, rvalid, low_run, high_run;
	wire logic wd_en, wd_act, wd_svc, intr_low, intr_high, irq;
	wire logic [1:0] bresp, rresp, mode;
	wire logic [31:0] rdata, rel_lo, rel_hi;
	int errors, samples_checked, cycles, n_lo, n_hi, n_svc, b_lo, b_hi, b_svc;
	tw_row_t rows [7];
	tw_regs u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cnt_low(cnt_low), .cnt_high(cnt_high),
		.match_low(evts[0]), .match_high(evts[1]), .capture_low_evt(evts[2]),
		.capture_high_evt(evts[3]), .wd_timeout(evts[4]),
		.reload_low_half(rel_lo), .reload_high_half(rel_hi), .timer_mode_select(mode),
		.low_half_run(low_run), .high_half_run(high_run), .watchdog_enable(wd_en),
		.watchdog_active(wd_act), .wd_service(wd_svc),
		.intr_low(intr_low), .intr_high(intr_high), .irq(irq)
	);
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task automatic complete_run();
		$display("checks=%0d errors=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// pulses are counted from pre-edge values, so no race with the design
	always @(posedge aclk) begin
		cycles++;
		n_lo += int'(intr_low === 1'b1);
		n_hi += int'(intr_high === 1'b1);
		n_svc += int'(wd_svc === 1'b1);
		if (cycles == 5000) begin
			errors++;
			complete_run();
		end
	end
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'hF);
		logic got;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		got = 1'b0;
		while (!got) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				last_b = bresp;
				bready <= 1'b0;
				got = 1'b1;
			end
		end
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d);
		logic got;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		got = 1'b0;
		while (!got) begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				last_r = rresp;
				rready <= 1'b0;
				got = 1'b1;
			end
		end
	endtask
	task automatic rchk(logic [7:0] a, logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	task automatic evt(logic [4:0] m);
		@(posedge aclk);
		evts <= m;
		@(posedge aclk);
		evts <= 5'h0;
	endtask
	// interrupt and service pulses seen since the previous call
	task automatic pulses(int lo, int hi, int svc);
		repeat (4) @(posedge aclk);
		chk(32'(n_lo - b_lo), 32'(lo));
		chk(32'(n_hi - b_hi), 32'(hi));
		chk(32'(n_svc - b_svc), 32'(svc));
		b_lo = n_lo;
		b_hi = n_hi;
		b_svc = n_svc;
	endtask
	initial begin
		rows = '{
			'{OFS_REL_LO, 32'hDEAD_BEEF, 4'hF, 32'hDEAD_BEEF, RESP_OKAY, RESP_OKAY},
			'{OFS_REL_HI, 32'h0123_4567, 4'hF, 32'h0123_4567, RESP_OKAY, RESP_OKAY},
			'{OFS_REL_LO, 32'hFFFF_FFFF, 4'h3, 32'hDEAD_FFFF, RESP_OKAY, RESP_OKAY},
			'{OFS_CAP_LO, 32'h5555_5555, 4'hF, 32'h0000_0000, RESP_OKAY, RESP_OKAY},
			'{OFS_CAP_HI, 32'h5555_5555, 4'hF, 32'h0000_0000, RESP_OKAY, RESP_OKAY},
			'{8'h24, 32'h5555_5555, 4'hF, 32'h0000_0000, RESP_SLVERR, RESP_SLVERR},
			'{OFS_IRQ_MASK, 32'h0000_0006, 4'hF, 32'h0000_0006, RESP_OKAY, RESP_OKAY}
		};
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wstrb, evts} = 25'h0;
		{wdata, cnt_low, cnt_high} = 96'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(OFS_WDCTL, 32'h0000_0000);
		rchk(OFS_ICTL, 32'h0000_0000);
		chk(32'(wd_en), 32'h0000_0000);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].s);
			chk(32'(last_b), 32'(rows[i].br));
			rchk(rows[i].a, rows[i].r);
			chk(32'(last_r), 32'(rows[i].rr));
		end
		chk(rel_lo, 32'hDEAD_FFFF);
		chk(rel_hi, 32'h0123_4567);
		pulses(0, 0, 0);
		// forced pulses with every enable and status still clear
		wr(OFS_ICTL, 32'h8000_0000);
		pulses(0, 1, 0);
		wr(OFS_ICTL, 32'h0000_8000);
		pulses(1, 0, 0);
		rchk(OFS_ICTL, 32'h0000_0000);
		cnt_low <= 32'h1234_5678;
		cnt_high <= 32'h9ABC_DEF0;
		evt(5'b01100);
		pulses(0, 0, 0);
		rchk(OFS_CAP_LO, 32'h1234_5678);
		rchk(OFS_CAP_HI, 32'h9ABC_DEF0);
		rchk(OFS_ICTL, 32'h0008_0008);
		wr(OFS_ICTL, 32'h4000_4000);
		pulses(1, 1, 0);
		wr(OFS_ICTL, 32'h0008_0008);
		rchk(OFS_ICTL, 32'h0000_0000);
		wr(OFS_ICTL, 32'h4000_4000);
		pulses(0, 0, 0);
		wr(OFS_ICTL, 32'h0000_0004);
		evt(5'b00100);
		pulses(1, 0, 0);
		wr(OFS_ICTL, 32'h0001_0009);
		rchk(OFS_ICTL, 32'h0001_0001);
		// both halves still held in reset, so matches must be ignored
		evt(5'b00011);
		pulses(0, 0, 0);
		rchk(OFS_ICTL, 32'h0001_0001);
		wr(OFS_TCTL, 32'h0000_0003);
		chk(32'({high_run, low_run}), 32'h0000_0003);
		evt(5'b00011);
		pulses(1, 1, 0);
		rchk(OFS_ICTL, 32'h0003_0003);
		wr(OFS_IRQ_ST, 32'h0000_0007);
		wr(OFS_IRQ_MASK, 32'h0000_0000);
		evt(5'b10000);
		pulses(0, 0, 0);
		chk(32'(irq), 32'h0000_0000);
		rchk(OFS_IRQ_ST, 32'h0000_0001);
		rchk(OFS_WDCTL, 32'h0000_8000);
		wr(OFS_IRQ_MASK, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0001);
		wr(OFS_IRQ_ST, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		wr(OFS_WDCTL, 32'h0000_8000, 4'h2);
		rchk(OFS_WDCTL, 32'h0000_0000);
		evt(5'b10000);
		pulses(0, 0, 0);
		wr(OFS_WDCTL, 32'h0000_4000);
		rchk(OFS_WDCTL, 32'h0000_4000);
		chk(32'(wd_en), 32'h0000_0001);
		// reserved bits 13..12 always written as zero
		wr(OFS_WDCTL, {KEY_FIRST, 16'h4000});
		wr(OFS_WDCTL, {KEY_SECOND, 16'h4000});
		pulses(0, 0, 0);
		wr(OFS_TCTL, 32'h0000_0008);
		chk(32'(wd_act), 32'h0000_0001);
		chk(32'(mode), 32'(MODE_WATCHDOG));
		wr(OFS_TCTL, 32'h0000_0003);
		rchk(OFS_TCTL, 32'h0000_0008);
		chk(32'({high_run, low_run}), 32'h0000_0000);
		wr(OFS_WDCTL, {KEY_FIRST, 16'h4000});
		wr(OFS_WDCTL, {KEY_SECOND, 16'h4000});
		pulses(0, 0, 1);
		// wrong order and an interrupted pair must not service
		wr(OFS_WDCTL, {KEY_SECOND, 16'h4000});
		wr(OFS_WDCTL, {KEY_FIRST, 16'h4000});
		wr(OFS_WDCTL, {16'h1111, 16'h4000});
		wr(OFS_WDCTL, {KEY_SECOND, 16'h4000});
		pulses(0, 0, 0);
		// mid-run reset must drop flag, enable, mode and the pending irq
		evt(5'b10000);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(OFS_WDCTL, 32'h0000_0000);
		rchk(OFS_TCTL, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		complete_run();
	end
endmodule
`default_nettype wire
